// ===== include/tdw_pkg.sv
// Package: constants and types for the transmit DMA write channel and its controller
package tdw_pkg;

    // ==========================================================
    // Device configuration register
    localparam logic [11:0] TDW_CFG_OFFSET = 12'h118;
    localparam logic [7:0]  TDW_CFG_RESET  = 8'h00;
    localparam logic [7:0]  TDW_CFG_WMASK  = 8'he7;  // Bits 4:3 read zero
    localparam int          TDW_RST_BIT    = 7;
    localparam int          TDW_ENB_BIT    = 6;
    localparam int          TDW_ROLE_BIT   = 5;
    localparam int          TDW_CHAN_MSB   = 2;
    localparam int          TDW_CHAN_LSB   = 0;
    localparam logic [2:0]  TDW_CHAN_0     = 3'h0;
    localparam logic [2:0]  TDW_CHAN_2     = 3'h2;
    localparam int          TDW_MSG_WORDS  = 16;

    // ==========================================================
    // Controller APB register map
    localparam logic [7:0]  TDW_A_CTRL     = 8'h00;
    localparam logic [7:0]  TDW_A_STAT     = 8'h04;
    localparam logic [7:0]  TDW_A_CFGW     = 8'h08;
    localparam logic [7:0]  TDW_A_SRC      = 8'h0c;
    localparam logic [7:0]  TDW_A_LEN      = 8'h10;
    localparam int          TDW_CTRL_START = 0;
    localparam int          TDW_STAT_BUSY  = 0;
    localparam int          TDW_STAT_DONE  = 1;
    localparam int          TDW_STAT_REM   = 16;
    localparam int          TDW_LEN_W      = 16;

    // ==========================================================
    // State encodings
    typedef enum logic [1:0] {
        TDW_D_IDLE = 2'h1,
        TDW_D_REQ  = 2'h2
    } tdw_dev_st_t;

    typedef enum logic [5:0] {
        TDW_C_IDLE = 6'h01,
        TDW_C_CFG  = 6'h02,
        TDW_C_WAIT = 6'h04,
        TDW_C_DRV  = 6'h08,
        TDW_C_SLO  = 6'h10,
        TDW_C_SHI  = 6'h20
    } tdw_ctl_st_t;

    // Only channel 0 and channel 2 codes carry a channel
    function automatic logic tdw_chan_ok(input logic [2:0] chan);
        return (chan == TDW_CHAN_0) || (chan == TDW_CHAN_2);
    endfunction

endpackage

// ===== include/tdw_if.sv
// Interface: microprocessor bus and DMA handshake between controller and framer
`timescale 1ns/1ns
interface tdw_if #(
    parameter int AW = 12,
    parameter int DW = 8
);
    logic          req_n;
    logic          ack_n;
    logic          cs_n;
    logic          wr_n;
    logic          rd_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport dev (
        output req_n,
        output rdata,
        input  ack_n,
        input  cs_n,
        input  wr_n,
        input  rd_n,
        input  addr,
        input  wdata
    );

    modport ctl (
        input  req_n,
        input  rdata,
        output ack_n,
        output cs_n,
        output wr_n,
        output rd_n,
        output addr,
        output wdata
    );
endinterface

// ===== hw/tdw_fall_det.sv
// Falling-edge detector for an active-low strobe pin
`timescale 1ns/1ns
module tdw_fall_det (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic strobe_n,
    output logic      fell
);
    logic prev_q;
    logic prev_d;

    // Idle level is high, so reset to high avoids a false edge
    always_comb begin
        prev_d = strobe_n;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign fell = prev_q & ~strobe_n;
endmodule

// ===== hw/tdw_dev.sv
// Framer end: transmit DMA write channel with its configuration register
// Behaviour
// - Rising reset bit resets the channel
// - Enable bit gates the write interface
// - Request only when buffer has message room
// - Data flows controller memory to transmit buffer
// - Request low starts; acknowledge low follows
// - Write strobe role: data on write low
// - Direction role: data on read low
// - Bit 5 selects write pin role
// - Bits 2:0 select channel; only codes 0 and 2 valid
`timescale 1ns/1ns
module tdw_dev
    import tdw_pkg::*;
#(
    parameter int AW        = 12,
    parameter int DW        = 8,
    parameter int MSG_WORDS = TDW_MSG_WORDS
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    tdw_if.dev          bus,
    input  wire logic   tx_room,
    output logic [DW-1:0] tx_data,
    output logic        tx_valid,
    output logic        tx_msg_end,
    output logic [2:0]  tx_chan
);
    localparam int CW = (MSG_WORDS > 1) ? $clog2(MSG_WORDS) : 1;
    localparam logic [CW-1:0] LAST = CW'(MSG_WORDS - 1);

    // ==========================================================
    // Strobe edge detection
    logic [1:0] pin_n;
    logic [1:0] pin_fell;
    logic       wr_fell;
    logic       rd_fell;

    assign pin_n   = {bus.rd_n, bus.wr_n};
    assign wr_fell = pin_fell[0];
    assign rd_fell = pin_fell[1];

    // One detector per strobe pin
    generate
        for (genvar i = 0; i < 2; i++) begin : g_edge
            tdw_fall_det u_fall (
                .pclk     (pclk),
                .presetn  (presetn),
                .strobe_n (pin_n[i]),
                .fell     (pin_fell[i])
            );
        end
    endgenerate

    // ==========================================================
    // Configuration register
    logic [7:0]    cfg_q;
    logic [7:0]    cfg_d;
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rdata_d;
    logic          addr_hit;
    logic          reg_wr;
    logic          chan_rst;
    logic          enb;
    logic          role_wr;
    logic [2:0]    chan;
    logic          chan_ok;

    assign addr_hit = (bus.addr == AW'(TDW_CFG_OFFSET));

    // Register writes are blocked while acknowledge is low: in the
    // direction role the write pin falls at acknowledge time
    assign reg_wr = ~bus.cs_n & bus.ack_n & addr_hit & wr_fell;

    // Only a 0 to 1 change of the reset bit acts
    assign chan_rst = reg_wr & bus.wdata[TDW_RST_BIT] & ~cfg_q[TDW_RST_BIT];

    assign enb     = cfg_q[TDW_ENB_BIT];
    assign role_wr = cfg_q[TDW_ROLE_BIT];
    assign chan    = cfg_q[TDW_CHAN_MSB:TDW_CHAN_LSB];
    assign chan_ok = tdw_chan_ok(chan);

    // Next value of the register and of the read path
    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr) begin
            cfg_d = 8'(bus.wdata) & TDW_CFG_WMASK;
        end
        rdata_d = '0;
        if (~bus.cs_n & addr_hit) begin
            rdata_d = DW'(cfg_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q   <= TDW_CFG_RESET;
            rdata_q <= '0;
        end else begin
            cfg_q   <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus.rdata = rdata_q;

    // ==========================================================
    // Request and data capture
    tdw_dev_st_t   st_q;
    tdw_dev_st_t   st_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          req_n_q;
    logic          req_n_d;
    logic [DW-1:0] txd_q;
    logic [DW-1:0] txd_d;
    logic          txv_q;
    logic          txv_d;
    logic          end_q;
    logic          end_d;
    logic [2:0]    chan_q;
    logic          strobe;
    logic          take;

    // Data strobe follows the selected pin role
    assign strobe = role_wr ? wr_fell : rd_fell;

    // A word is taken only inside an acknowledged request
    assign take = (st_q == TDW_D_REQ) & ~bus.ack_n & strobe;

    // The room check is made once per message, at request time,
    // so a buffer that fills mid-message cannot cut it short
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        txd_d = txd_q;
        txv_d = 1'b0;
        end_d = 1'b0;
        unique case (st_q)
            TDW_D_IDLE: begin
                cnt_d = '0;
                if (enb & chan_ok & tx_room) begin
                    st_d = TDW_D_REQ;
                end
            end
            TDW_D_REQ: begin
                if (~enb | ~chan_ok) begin
                    st_d = TDW_D_IDLE;
                end else if (take) begin
                    txd_d = bus.wdata;
                    txv_d = 1'b1;
                    if (cnt_q == LAST) begin
                        end_d = 1'b1;
                        cnt_d = '0;
                        st_d  = TDW_D_IDLE;
                    end else begin
                        cnt_d = cnt_q + CW'(1);
                    end
                end
            end
        endcase
        if (chan_rst) begin
            st_d  = TDW_D_IDLE;
            cnt_d = '0;
            txv_d = 1'b0;
            end_d = 1'b0;
        end
        req_n_d = (st_d != TDW_D_REQ);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= TDW_D_IDLE;
            cnt_q   <= '0;
            req_n_q <= 1'b1;
            txd_q   <= '0;
            txv_q   <= 1'b0;
            end_q   <= 1'b0;
            chan_q  <= TDW_CHAN_0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            req_n_q <= req_n_d;
            txd_q   <= txd_d;
            txv_q   <= txv_d;
            end_q   <= end_d;
            chan_q  <= chan;
        end
    end

    // ==========================================================
    // Outputs
    assign bus.req_n  = req_n_q;
    assign tx_data    = txd_q;
    assign tx_valid   = txv_q;
    assign tx_msg_end = end_q;
    assign tx_chan    = chan_q;
endmodule

// ===== hw/tdw_ctl.sv
// Controller end: APB-programmed DMA controller feeding the framer write channel
`timescale 1ns/1ns
module tdw_ctl
    import tdw_pkg::*;
#(
    parameter int AW  = 12,
    parameter int DW  = 8,
    parameter int MAW = 16
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic [7:0]     paddr,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    output logic [MAW-1:0]      mem_addr,
    input  wire logic [DW-1:0]  mem_rdata,
    tdw_if.ctl                  bus
);
    tdw_ctl_st_t          st_q, st_d;
    logic                 rdy_q, rdy_d, err_q, err_d;
    logic [31:0]          prd_q, prd_d;
    logic [7:0]           cfgw_q, cfgw_d;
    logic [MAW-1:0]       src_q, src_d, ma_q, ma_d;
    logic [TDW_LEN_W-1:0] len_q, len_d, rem_q, rem_d;
    logic                 pcfg_q, pcfg_d, pgo_q, pgo_d, done_q, done_d;
    logic                 role_q, role_d, ack_q, ack_d, cs_q, cs_d;
    logic                 wr_q, wr_d, rd_q, rd_d;
    logic [DW-1:0]        wd_q, wd_d;
    logic                 wacc, mapped, fin;

    assign wacc   = psel & penable & rdy_q & pwrite;
    assign mapped = (paddr == TDW_A_CTRL) | (paddr == TDW_A_STAT) | (paddr == TDW_A_CFGW)
                  | (paddr == TDW_A_SRC) | (paddr == TDW_A_LEN);

    // ==========================================================
    // APB slave: answers one cycle after setup, no wait states
    always_comb begin
        rdy_d  = psel & ~penable;
        err_d  = psel & ~penable & ~mapped;
        prd_d  = '0;
        cfgw_d = cfgw_q;
        src_d  = src_q;
        len_d  = len_q;
        pcfg_d = pcfg_q;
        pgo_d  = pgo_q;
        unique case (paddr)
            TDW_A_STAT: begin
                prd_d[TDW_STAT_BUSY] = (st_q != TDW_C_IDLE);
                prd_d[TDW_STAT_DONE] = done_q;
                prd_d[TDW_STAT_REM +: TDW_LEN_W] = rem_q;
            end
            TDW_A_CFGW: prd_d[7:0] = cfgw_q;
            TDW_A_SRC:  prd_d[MAW-1:0] = src_q;
            TDW_A_LEN:  prd_d[TDW_LEN_W-1:0] = len_q;
            default:    prd_d = '0;
        endcase
        if (wacc) begin
            if (paddr == TDW_A_CFGW) begin
                cfgw_d = pwdata[7:0];
                pcfg_d = 1'b1;
            end
            if (paddr == TDW_A_SRC) begin
                src_d = pwdata[MAW-1:0];
            end
            if (paddr == TDW_A_LEN) begin
                len_d = pwdata[TDW_LEN_W-1:0];
            end
            if ((paddr == TDW_A_CTRL) & pwdata[TDW_CTRL_START]) begin
                pgo_d = 1'b1;
            end
        end
        // A pending order is dropped once the sequencer has taken it
        if (st_q == TDW_C_IDLE) begin
            if (pcfg_q) begin
                pcfg_d = wacc & (paddr == TDW_A_CFGW);
            end else if (pgo_q) begin
                pgo_d = wacc & (paddr == TDW_A_CTRL) & pwdata[TDW_CTRL_START];
            end
        end
    end

    // ==========================================================
    // Bus sequencer: configuration writes and DMA word strobes
    always_comb begin
        st_d   = st_q;
        ma_d   = ma_q;
        rem_d  = rem_q;
        role_d = role_q;
        ack_d  = ack_q;
        cs_d   = 1'b1;
        wr_d   = wr_q;
        rd_d   = 1'b1;
        wd_d   = wd_q;
        fin    = 1'b0;
        unique case (st_q)
            TDW_C_IDLE: begin
                wr_d = 1'b1;
                if (pcfg_q) begin
                    cs_d   = 1'b0;
                    wr_d   = 1'b0;
                    wd_d   = DW'(cfgw_q);
                    role_d = cfgw_q[TDW_ROLE_BIT];
                    st_d   = TDW_C_CFG;
                end else if (pgo_q) begin
                    ma_d  = src_q;
                    rem_d = len_q;
                    st_d  = TDW_C_WAIT;
                end
            end
            TDW_C_CFG: begin
                wr_d = 1'b1;
                st_d = TDW_C_IDLE;
            end
            TDW_C_WAIT: begin
                if (rem_q == '0) begin
                    fin  = 1'b1;
                    st_d = TDW_C_IDLE;
                end else if (~bus.req_n) begin
                    ack_d = 1'b0;
                    wr_d  = role_q;       // Direction role holds write low
                    st_d  = TDW_C_DRV;
                end
            end
            TDW_C_DRV: begin
                wd_d = mem_rdata;
                if (role_q) begin
                    wr_d = 1'b0;
                end else begin
                    rd_d = 1'b0;
                end
                st_d = TDW_C_SLO;
            end
            TDW_C_SLO: begin
                wr_d  = role_q ? 1'b1 : wr_q;
                ma_d  = ma_q + MAW'(1);
                rem_d = rem_q - TDW_LEN_W'(1);
                st_d  = TDW_C_SHI;
            end
            TDW_C_SHI: begin
                if ((rem_q == '0) | bus.req_n) begin
                    ack_d = 1'b1;
                    wr_d  = 1'b1;
                    fin   = (rem_q == '0);
                    st_d  = (rem_q == '0) ? TDW_C_IDLE : TDW_C_WAIT;
                end else begin
                    st_d = TDW_C_DRV;
                end
            end
        endcase
        // Done is sticky; a new finish wins over a clear in the same cycle
        done_d = done_q;
        if (wacc & (paddr == TDW_A_STAT) & pwdata[TDW_STAT_DONE]) begin
            done_d = 1'b0;
        end
        if (fin) begin
            done_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= TDW_C_IDLE;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            prd_q <= '0;
            cfgw_q <= TDW_CFG_RESET;
            src_q <= '0;
            len_q <= '0;
            pcfg_q <= 1'b0;
            pgo_q <= 1'b0;
            done_q <= 1'b0;
            ma_q <= '0;
            rem_q <= '0;
            role_q <= 1'b0;
            ack_q <= 1'b1;
            cs_q <= 1'b1;
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            wd_q <= '0;
        end else begin
            st_q <= st_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
            prd_q <= prd_d;
            cfgw_q <= cfgw_d;
            src_q <= src_d;
            len_q <= len_d;
            pcfg_q <= pcfg_d;
            pgo_q <= pgo_d;
            done_q <= done_d;
            ma_q <= ma_d;
            rem_q <= rem_d;
            role_q <= role_d;
            ack_q <= ack_d;
            cs_q <= cs_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            wd_q <= wd_d;
        end
    end

    assign prdata    = prd_q;
    assign pready    = rdy_q;
    assign pslverr   = err_q;
    assign mem_addr  = ma_q;
    assign bus.ack_n = ack_q;
    assign bus.cs_n  = cs_q;
    assign bus.wr_n  = wr_q;
    assign bus.rd_n  = rd_q;
    assign bus.addr  = AW'(TDW_CFG_OFFSET);
    assign bus.wdata = wd_q;
endmodule

// ===== testbench/tdw_chk_asserts.sv
// Checker: timing rules of the DMA link between controller and framer
`timescale 1ns/1ns
module tdw_chk
    import tdw_pkg::*;
#(
    parameter int MSG_WORDS = TDW_MSG_WORDS
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        req_n,
    input wire logic        ack_n,
    input wire logic        cs_n,
    input wire logic        wr_n,
    input wire logic        rd_n,
    input wire logic [11:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic        tx_room,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_msg_end,
    input wire logic [2:0]  tx_chan
);
    logic [7:0]  cfg_q, cfg_d;
    logic [15:0] cnt_q, cnt_d;
    logic        wr_prev_q, cfg_wr, strobe_n, chan_ok;

    // ==========================================================
    // Shadow of the device configuration, taken on the same write edge
    always_comb begin
        cfg_wr   = !cs_n && ack_n && (addr == TDW_CFG_OFFSET) && !wr_n && wr_prev_q;
        cfg_d    = cfg_wr ? (wdata & TDW_CFG_WMASK) : cfg_q;
        strobe_n = cfg_q[TDW_ROLE_BIT] ? wr_n : rd_n;
        chan_ok  = (cfg_q[2:0] == 3'h0) || (cfg_q[2:0] == 3'h2);
        // Word count restarts whenever the request is withdrawn
        cnt_d    = tx_valid ? (tx_msg_end ? 16'h0 : cnt_q + 16'h1) : (req_n ? 16'h0 : cnt_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q     <= 8'h00;
            cnt_q     <= 16'h0;
            wr_prev_q <= 1'b1;
        end else begin
            cfg_q     <= cfg_d;
            cnt_q     <= cnt_d;
            wr_prev_q <= wr_n;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_req_needs_enb: assert property ($fell(req_n) |-> $past(cfg_q[6]))
        else $error("request raised while disabled");
    a_enb_off_drop: assert property (!cfg_q[6] |-> ##[0:1] req_n)
        else $error("request held while disabled");
    a_req_needs_room: assert property ($fell(req_n) |-> $past(tx_room))
        else $error("request raised without buffer room");
    a_bad_chan_drop: assert property (!chan_ok |-> ##[0:1] req_n)
        else $error("request held on reserved channel");
    a_req_valid_chan: assert property ($fell(req_n) |-> $past(chan_ok))
        else $error("request raised on reserved channel");
    a_ack_after_req: assert property ($fell(ack_n) |-> !$past(req_n))
        else $error("acknowledge without request");
    a_strobe_takes: assert property ($fell(strobe_n) && !ack_n && !req_n |=> tx_valid)
        else $error("strobe did not deliver a word");
    a_word_source: assert property (tx_valid |-> !$past(strobe_n) && !$past(ack_n))
        else $error("word without selected strobe");
    a_word_data: assert property (tx_valid |-> tx_data == $past(wdata))
        else $error("word data differs from bus");
    a_msg_count: assert property (tx_valid |->
        (tx_msg_end == (cnt_q == 16'(MSG_WORDS - 1))) && (req_n == tx_msg_end))
        else $error("message end misplaced");
    a_rst_bit: assert property (cfg_wr && wdata[7] && !cfg_q[7] |-> ##[1:2] req_n)
        else $error("channel reset did not drop request");
    a_chan_out: assert property ($stable(cfg_q) ##1 $stable(cfg_q) |-> tx_chan == cfg_q[2:0])
        else $error("channel output differs from field");
    // Read path shows the stored value, reserved bits as zero, one cycle after select
    a_cfg_readback: assert property (!cs_n |=> rdata == $past(cfg_q))
        else $error("register read data differs from configuration");
    a_rdata_idle: assert property (cs_n |=> rdata == 8'h00)
        else $error("read data driven without chip select");
endmodule

// ===== testbench/transmit_dma_write_channel_tb_top.sv
// Testbench: controller and framer joined through the bus interface
`timescale 1ns/1ns
module transmit_dma_write_channel_tb_top
    import tdw_pkg::*;
;
    localparam int MSGW = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        tx_room, tx_valid, tx_msg_end;
    logic [7:0]  paddr, mem_rdata, tx_data;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mem_addr;
    logic [2:0]  tx_chan;
    logic [7:0]  got[$];
    int          n_errors, checked, cyc, nend, words;
    integer      seed = 32'h1a436d91;

    tdw_if bus_if ();
    tdw_dev #(.MSG_WORDS(MSGW)) tdw_dev_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if.dev),
        .tx_room(tx_room), .tx_data(tx_data), .tx_valid(tx_valid), .tx_msg_end(tx_msg_end),
        .tx_chan(tx_chan));
    tdw_ctl tdw_ctl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .bus(bus_if.ctl));
    tdw_chk #(.MSG_WORDS(MSGW)) tdw_chk_inst (.pclk(pclk), .presetn(presetn),
        .req_n(bus_if.req_n), .ack_n(bus_if.ack_n), .cs_n(bus_if.cs_n), .wr_n(bus_if.wr_n),
        .rd_n(bus_if.rd_n), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata), .tx_room(tx_room),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_msg_end(tx_msg_end), .tx_chan(tx_chan));

    // ==========================================================
    // Clock, memory with one cycle of read latency, word monitor
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    function automatic logic [7:0] mem_fn(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // Request is expected only when enabled, with room, on channel 0 or 2
    function automatic logic req_exp(input logic [7:0] c, input logic room);
        return !(c[6] && room && (c[2:0] == 3'h0 || c[2:0] == 3'h2));
    endfunction

    always @(posedge pclk) begin
        mem_rdata <= mem_fn(mem_addr);
        cyc++;
        if (tx_valid === 1'b1) got.push_back(tx_data);
        if (tx_msg_end === 1'b1) nend++;
        if (cyc == 40000) begin  // Hang guard
            n_errors++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Only pready or the hang guard ends this wait; the latency is checked afterwards
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        chk(n, 1);  // Slave answers in the first access cycle
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic cfg_probe(input logic [7:0] c, input logic room);
        tx_room <= room;
        apb(1'b1, TDW_A_CFGW, {24'h0, c});
        repeat (8) @(posedge pclk);  // Room to settle
        chk(bus_if.req_n, req_exp(c, room));
        chk(tx_chan, c[2:0]);
    endtask

    task automatic run_dma(input logic [7:0] cfg, input int nw);
        logic [15:0] src;
        int          i;
        src = 16'($random(seed)) & 16'hfff0;
        got.delete();
        nend = 0;
        apb(1'b1, TDW_A_CFGW, {24'h0, cfg});
        apb(1'b1, TDW_A_SRC, {16'h0, src});
        apb(1'b1, TDW_A_LEN, 32'(nw));
        apb(1'b1, TDW_A_CTRL, 32'h1);
        i = 0;
        do begin
            apb(1'b0, TDW_A_STAT, 32'h0);
            i++;
        end while (rd[TDW_STAT_DONE] !== 1'b1 && i < 200);
        chk(rd, 32'h2);
        chk(got.size(), nw);
        foreach (got[k]) chk(got[k], mem_fn(src + 16'(k)));
        chk(nend, nw / MSGW);
        apb(1'b1, TDW_A_STAT, 32'h2);
        apb(1'b0, TDW_A_STAT, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; tx_room = 1'b0; mem_rdata = 8'h00;
        n_errors = 0; checked = 0; cyc = 0; nend = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(bus_if.req_n, 1'b1);
        chk(tx_chan, 3'h0);
        apb(1'b0, TDW_A_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h44, 32'hffffffff);
        chk(err, 1'b1);
        $display("test reset and map done");
        // Every channel code; odd codes also set the reserved bits
        for (int c = 0; c < 8; c++) begin
            cfg_probe(8'h60 | 8'(c) | ((c % 2) ? 8'h18 : 8'h00), 1'b1);
        end
        $display("test channel codes done");
        cfg_probe(8'h20, 1'b1);
        cfg_probe(8'h60, 1'b0);
        cfg_probe(8'he0, 1'b1);
        cfg_probe(8'h60, 1'b1);
        $display("test enable room reset done");
        for (int r = 1; r >= 0; r--) begin
            words = MSGW * (1 + ($random(seed) & 1));
            run_dma(8'h40 | 8'(r << 5) | ((($random(seed) & 1) != 0) ? 8'h02 : 8'h00), words);
            $display("test transfer role %0d done", r);
        end
        report_and_stop();
    end
endmodule
